/* verilog/wowdt_map.svh */
// register layout, reset values and field positions of the write-once watchdog
// What this block does
// - After reset the watchdog counts by itself in reset mode, with no software write needed.
// - The mode register takes only the first write after reset, and only a byte-wide one.
// - One byte write sets the action and interval, and after it the watchdog cannot be halted.
// - A five-bit interval field in the mode register sets how long the count runs to overflow.
// - A byte-wide write of ACH to the service register clears the counter and restarts it from zero.
// - On overflow the block raises its reset output or its NMI request, as the action bits pick.
// - In reset mode an overflow during oscillation settling moves the CPU clock to the oscillator.
// - Writing 1FH to the mode register stops the watchdog for good.
// - The mode register holds 67H after reset, reset mode with the longest oscillator interval.
// - The service register reads and writes as a byte and holds 9AH after reset.
// - Codes 0-7 pick 2^12..2^19 oscillator ticks, 8-15 pick 2^16..2^23 main ticks, 1FH stops.
`ifndef WOWDT_MAP_SVH
`define WOWDT_MAP_SVH
`define WOWDT_MODE_RST 8'h67
`define WOWDT_SVC_RST 8'h9A
`define WOWDT_KEY 8'hAC
`define WOWDT_STOP_CODE 5'h1F
`define WOWDT_ACT_HI_BIT 6
`define WOWDT_ACT_LO_BIT 5
`define WOWDT_SEL_MSB 4
`define WOWDT_SEL_LSB 0
`define WOWDT_SRC_BIT 3
`define WOWDT_STEP_MSB 2
`define WOWDT_FR_BASE 5'h0C
`define WOWDT_FXX_BASE 5'h10
`define WOWDT_CNT_W 24
`endif

/* verilog/wowdt_pkg.sv */
// types shared by the write-once watchdog modules
package wowdt_pkg;
  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] svc;
    logic locked;
    logic rst_out;
    logic nmi;
    logic clk_osc;
  } wowdt_state_t;
endpackage : wowdt_pkg

/* verilog/wowdt_counter.sv */
// interval counter with power-of-two overflow limit
`timescale 1ns/10ps
`include "wowdt_map.svh"
module wowdt_counter #(
  parameter int CNT_W = `WOWDT_CNT_W
) (
  input wire logic clk, // main clock
  input wire logic rst, // async reset, high
  input wire logic tick, // one count step
  input wire logic clr, // restart from zero
  input wire logic run, // counting allowed
  input wire logic [4:0] lim_log2, // overflow after 2^n steps
  output logic [CNT_W-1:0] count, // current count
  output logic ovf // overflow pulse
);
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
  } wowdt_cnt_state_t;

  wowdt_cnt_state_t st_r;
  wowdt_cnt_state_t st_nxt;
  logic [CNT_W-1:0] lim;

  // narrower cannot hold the longest limit, wider overruns the shift amount
  if (CNT_W < 24 || CNT_W > 31) begin : g_bad_cnt_w
    $error("wowdt_counter: CNT_W must be 24..31");
  end

  assign lim = ~({CNT_W{1'b1}} << lim_log2);
  assign ovf = run && tick && !clr && (st_r.cnt == lim);
  assign count = st_r.cnt;

  always_comb begin
    st_nxt = st_r;
    if (clr || !run) begin
      st_nxt.cnt = '0;
    end else if (tick) begin
      if (st_r.cnt == lim) begin
        st_nxt.cnt = '0;
      end else begin
        st_nxt.cnt = st_r.cnt + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_ovf_at_limit;
    ovf |-> (st_r.cnt == lim) && tick ##1 (st_r.cnt == '0);
  endproperty
  a_ovf_at_limit: assert property (p_ovf_at_limit) else $error("overflow off limit");

  property p_clr_zero;
    clr |=> (st_r.cnt == '0) && !ovf;
  endproperty
  a_clr_zero: assert property (p_clr_zero) else $error("clear did not zero count");
endmodule : wowdt_counter

/* verilog/wowdt_top.sv */
// write-once watchdog timer with service key and overflow action select
`timescale 1ns/10ps
`include "wowdt_map.svh"
module wowdt_top #(
  parameter int CNT_W = `WOWDT_CNT_W
) (
  input wire logic clk, // main clock, 100 MHz
  input wire logic rst, // async reset, high
  input wire logic fr_tick, // internal oscillator period strobe
  input wire logic fxx_tick, // main clock period strobe
  input wire logic osc_stab, // oscillation settling in progress
  input wire logic mode_wr, // mode register write strobe
  input wire logic mode_byte, // mode write is byte wide
  input wire logic [7:0] mode_wdata, // mode write data
  output logic [7:0] mode_rdata, // mode register contents
  input wire logic svc_wr, // service register write strobe
  input wire logic svc_byte, // service write is byte wide
  input wire logic [7:0] svc_wdata, // service write data
  output logic [7:0] svc_rdata, // service register contents
  output logic guard_reset_out, // overflow reset pulse
  output logic guard_nmi_request, // overflow nmi pulse
  output logic cpu_clk_to_osc, // cpu clock moved to oscillator
  output logic mode_locked, // mode register already written
  output logic guard_running // watchdog counting
);
  wowdt_pkg::wowdt_state_t st_r;
  wowdt_pkg::wowdt_state_t st_nxt;
  logic [4:0] sel;
  logic stopped;
  logic src_main;
  logic tick;
  logic [4:0] lim_log2;
  logic key_wr;
  logic ovf;
  logic act_hi;
  logic [CNT_W-1:0] count;

  if (CNT_W < 24 || CNT_W > 31) begin : g_bad_cnt_w
    $error("wowdt_top: CNT_W must be 24..31");
  end

  assign sel = st_r.mode[`WOWDT_SEL_MSB:`WOWDT_SEL_LSB];
  assign act_hi = st_r.mode[`WOWDT_ACT_HI_BIT];
  // codes 10000..11110 are treated as stopped too
  assign stopped = sel[`WOWDT_SEL_MSB];
  assign src_main = sel[`WOWDT_SRC_BIT];
  assign tick = src_main ? fxx_tick : fr_tick;
  assign lim_log2 = (src_main ? `WOWDT_FXX_BASE : `WOWDT_FR_BASE)
                    + {2'b00, sel[`WOWDT_STEP_MSB:0]};
  assign key_wr = svc_wr && svc_byte && (svc_wdata == `WOWDT_KEY);

  // counting starts straight from reset on the default mode
  wowdt_counter #(
    .CNT_W(CNT_W)
  ) u_counter (
    .clk(clk),
    .rst(rst),
    .tick(tick),
    .clr(key_wr),
    .run(!stopped),
    .lim_log2(lim_log2),
    .count(count),
    .ovf(ovf)
  );

  always_comb begin
    st_nxt = st_r;
    st_nxt.rst_out = 1'b0;
    st_nxt.nmi = 1'b0;
    // only the first byte write is taken; a wide write is dropped
    if (mode_wr && mode_byte && !st_r.locked) begin
      st_nxt.mode = mode_wdata;
      st_nxt.locked = 1'b1;
    end
    if (svc_wr && svc_byte) begin
      st_nxt.svc = svc_wdata;
    end
    if (ovf) begin
      if (act_hi) begin
        if (osc_stab) begin
          st_nxt.clk_osc = 1'b1;
        end else begin
          st_nxt.rst_out = 1'b1;
        end
      end else begin
        st_nxt.nmi = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r.mode <= `WOWDT_MODE_RST;
      st_r.svc <= `WOWDT_SVC_RST;
      st_r.locked <= 1'b0;
      st_r.rst_out <= 1'b0;
      st_r.nmi <= 1'b0;
      st_r.clk_osc <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign mode_rdata = st_r.mode;
  assign svc_rdata = st_r.svc;
  assign guard_reset_out = st_r.rst_out;
  assign guard_nmi_request = st_r.nmi;
  assign cpu_clk_to_osc = st_r.clk_osc;
  assign mode_locked = st_r.locked;
  assign guard_running = !stopped;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_default_mode;
    !st_r.locked |-> (st_r.mode == `WOWDT_MODE_RST) && guard_running;
  endproperty
  a_default_mode: assert property (p_default_mode) else $error("default mode lost");

  property p_first_write;
    mode_wr && mode_byte && !st_r.locked
      |=> st_r.locked && (mode_rdata == $past(mode_wdata));
  endproperty
  a_first_write: assert property (p_first_write) else $error("first mode write lost");

  property p_wide_refused;
    !st_r.locked && !(mode_wr && mode_byte) |=> !st_r.locked && $stable(st_r.mode);
  endproperty
  a_wide_refused: assert property (p_wide_refused) else $error("mode changed");

  property p_locked_hold;
    st_r.locked |=> st_r.locked && $stable(mode_rdata);
  endproperty
  a_locked_hold: assert property (p_locked_hold) else $error("locked mode changed");

  property p_key_restart;
    key_wr |=> (count == '0) && !guard_reset_out && !guard_nmi_request;
  endproperty
  a_key_restart: assert property (p_key_restart) else $error("key did not restart");

  property p_reset_action;
    ovf && act_hi && !osc_stab |=> guard_reset_out && !guard_nmi_request ##1 !guard_reset_out;
  endproperty
  a_reset_action: assert property (p_reset_action) else $error("reset pulse wrong");

  property p_nmi_action;
    ovf && !act_hi |=> guard_nmi_request && !guard_reset_out;
  endproperty
  a_nmi_action: assert property (p_nmi_action) else $error("nmi pulse wrong");

  property p_stab_switch;
    ovf && act_hi && osc_stab |=> cpu_clk_to_osc && !guard_reset_out;
  endproperty
  a_stab_switch: assert property (p_stab_switch) else $error("settling overflow reset");

  property p_stopped;
    stopped ##1 stopped |-> (count == '0) && !ovf ##1 !guard_reset_out && !guard_nmi_request;
  endproperty
  a_stopped: assert property (p_stopped) else $error("stopped watchdog counts");

  property p_no_halt;
    st_r.locked && !stopped |=> guard_running;
  endproperty
  a_no_halt: assert property (p_no_halt) else $error("watchdog halted");

  property p_fires_only_on_ovf;
    $rose(guard_reset_out) || $rose(guard_nmi_request) |-> $past(ovf);
  endproperty
  a_fires_only_on_ovf: assert property (p_fires_only_on_ovf) else $error("no cause");

  property p_svc_store;
    svc_wr && svc_byte |=> svc_rdata == $past(svc_wdata);
  endproperty
  a_svc_store: assert property (p_svc_store) else $error("svc not stored");

  property p_svc_refused;
    !(svc_wr && svc_byte) |=> $stable(svc_rdata);
  endproperty
  a_svc_refused: assert property (p_svc_refused) else $error("svc changed");

  property p_osc_sticky;
    cpu_clk_to_osc |=> cpu_clk_to_osc;
  endproperty
  a_osc_sticky: assert property (p_osc_sticky) else $error("clock switch lost");

  property p_osc_cause;
    $rose(cpu_clk_to_osc) |-> $past(ovf && act_hi && osc_stab);
  endproperty
  a_osc_cause: assert property (p_osc_cause) else $error("stray clock switch");

  property p_rst_pulse;
    guard_reset_out |=> !guard_reset_out;
  endproperty
  a_rst_pulse: assert property (p_rst_pulse) else $error("reset pulse long");

  property p_nmi_pulse;
    guard_nmi_request |=> !guard_nmi_request;
  endproperty
  a_nmi_pulse: assert property (p_nmi_pulse) else $error("nmi pulse long");

  property p_stop_write;
    mode_wr && mode_byte && !st_r.locked && mode_wdata[4:0] == `WOWDT_STOP_CODE
      |=> !guard_running;
  endproperty
  a_stop_write: assert property (p_stop_write) else $error("stop write ignored");

  property p_one_action;
    !(guard_reset_out && guard_nmi_request);
  endproperty
  a_one_action: assert property (p_one_action) else $error("both actions");

  property p_dflt_ivl;
    !st_r.locked |-> !src_main && (lim_log2 == `WOWDT_FR_BASE + 5'h07);
  endproperty
  a_dflt_ivl: assert property (p_dflt_ivl) else $error("default interval");

  property p_nmi_keeps_clk;
    ovf && !act_hi |=> $stable(cpu_clk_to_osc);
  endproperty
  a_nmi_keeps_clk: assert property (p_nmi_keeps_clk) else $error("nmi moved clock");

  c_reset_fire: cover property (ovf && act_hi && !osc_stab);
  c_stab_switch: cover property (ovf && act_hi && osc_stab);
  c_nmi_fire: cover property (st_r.locked && !act_hi ##1 guard_nmi_request);
  c_stop_write: cover property (mode_wr && mode_byte && !st_r.locked
                                && mode_wdata[4:0] == `WOWDT_STOP_CODE);
  c_second_write: cover property (st_r.locked && mode_wr && mode_byte);
endmodule : wowdt_top

/* bench/tb_write_once_watchdog_timer.sv */
// self-checking bench for the write-once watchdog top
`timescale 1ns/10ps
module tb_write_once_watchdog_timer;
  logic clk, rst, fr_tick, fxx_tick, osc_stab;
  logic mode_wr, mode_byte, svc_wr, svc_byte;
  logic [7:0] mode_wdata, svc_wdata, mode_rdata, svc_rdata;
  logic guard_reset_out, guard_nmi_request, cpu_clk_to_osc, mode_locked, guard_running;
  int n_mismatch = 0;
  int checks_done = 0;
  int n_r, n_n;

  wowdt_top dut_u (
    .clk(clk), .rst(rst), .fr_tick(fr_tick), .fxx_tick(fxx_tick), .osc_stab(osc_stab),
    .mode_wr(mode_wr), .mode_byte(mode_byte), .mode_wdata(mode_wdata),
    .mode_rdata(mode_rdata), .svc_wr(svc_wr), .svc_byte(svc_byte),
    .svc_wdata(svc_wdata), .svc_rdata(svc_rdata), .guard_reset_out(guard_reset_out),
    .guard_nmi_request(guard_nmi_request), .cpu_clk_to_osc(cpu_clk_to_osc),
    .mode_locked(mode_locked), .guard_running(guard_running)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic ok, input string msg);
    checks_done++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask : chk

  task automatic do_rst();
    rst = 1'b1;
    repeat (5) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
  endtask : do_rst

  // one-cycle mode write, issued from a falling edge
  task automatic wm(input logic b, input logic [7:0] d);
    mode_wr = 1'b1;
    mode_byte = b;
    mode_wdata = d;
    @(negedge clk);
    mode_wr = 1'b0;
    @(negedge clk);
  endtask : wm

  task automatic ws(input logic b, input logic [7:0] d);
    svc_wr = 1'b1;
    svc_byte = b;
    svc_wdata = d;
    @(negedge clk);
    svc_wr = 1'b0;
    @(negedge clk);
  endtask : ws

  // n steps with the chosen strobes; pulses counted at each falling edge
  task automatic run(input int n, input logic f, input logic x);
    n_r = 0;
    n_n = 0;
    fr_tick = f;
    fxx_tick = x;
    repeat (n) begin
      @(negedge clk);
      n_r += int'(guard_reset_out === 1'b1);
      n_n += int'(guard_nmi_request === 1'b1);
    end
    fr_tick = 1'b0;
    fxx_tick = 1'b0;
    @(negedge clk);
    n_r += int'(guard_reset_out === 1'b1);
    n_n += int'(guard_nmi_request === 1'b1);
  endtask : run

  task automatic sc_lock();
    wm(1'b0, 8'h00);
    chk(mode_rdata === 8'h67 && mode_locked === 1'b0, "word write taken");
    wm(1'b1, 8'h40);
    chk(mode_rdata === 8'h40 && mode_locked === 1'b1, "first write lost");
    wm(1'b1, 8'h1F);
    chk(mode_rdata === 8'h40 && guard_running === 1'b1, "second write taken");
  endtask : sc_lock

  task automatic sc_ovf();
    ws(1'b1, 8'h55);
    chk(svc_rdata === 8'h55, "service data not stored");
    ws(1'b0, 8'hAC);
    chk(svc_rdata === 8'h55, "word service write taken");
    ws(1'b1, 8'hAC);
    run(500, 1'b0, 1'b1);
    run(4000, 1'b1, 1'b0);
    chk(n_r == 0 && n_n == 0, "main ticks counted on oscillator code");
    // neither a plain byte nor a word-wide key may clear the count
    ws(1'b1, 8'h55);
    ws(1'b0, 8'hAC);
    run(95, 1'b1, 1'b0);
    chk(n_r == 0 && n_n == 0, "early overflow");
    run(1, 1'b1, 1'b0);
    chk(n_r == 1 && n_n == 0, "non-key write cleared count");
    run(2000, 1'b1, 1'b0);
    ws(1'b1, 8'hAC);
    run(4095, 1'b1, 1'b0);
    chk(n_r == 0 && n_n == 0, "early overflow after key");
    run(1, 1'b1, 1'b0);
    chk(n_r == 1 && n_n == 0, "no reset at 2^12 ticks");
    osc_stab = 1'b1;
    run(4096, 1'b1, 1'b0);
    chk(n_r == 0 && n_n == 0 && cpu_clk_to_osc === 1'b1, "settling overflow wrong");
    osc_stab = 1'b0;
  endtask : sc_ovf

  task automatic sc_nmi();
    do_rst();
    chk(cpu_clk_to_osc === 1'b0 && mode_locked === 1'b0, "mid-run reset");
    chk(mode_rdata === 8'h67 && svc_rdata === 8'h9A, "reset values after run");
    wm(1'b1, 8'h00);
    run(4096, 1'b1, 1'b0);
    chk(n_n == 1 && n_r == 0, "no nmi on overflow");
  endtask : sc_nmi

  task automatic sc_stop();
    do_rst();
    wm(1'b1, 8'h1F);
    chk(guard_running === 1'b0, "still running after stop");
    run(5000, 1'b1, 1'b1);
    chk(n_r == 0 && n_n == 0, "stopped timer overflowed");
    wm(1'b1, 8'h40);
    chk(mode_rdata === 8'h1F && guard_running === 1'b0, "restart after stop");
  endtask : sc_stop

  // main-clock code: oscillator ticks must not count
  task automatic sc_main();
    do_rst();
    wm(1'b1, 8'h48);
    run(500, 1'b1, 1'b0);
    run(65535, 1'b0, 1'b1);
    chk(n_r == 0 && n_n == 0, "early overflow on main clock");
    run(1, 1'b0, 1'b1);
    chk(n_r == 1 && n_n == 0, "no reset at 2^16 main ticks");
  endtask : sc_main

  task automatic stop_test();
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test

  initial begin
    {fr_tick, fxx_tick, osc_stab, mode_wr, mode_byte, svc_wr, svc_byte} = 7'h00;
    mode_wdata = 8'h00;
    svc_wdata = 8'h00;
    do_rst();
    chk(mode_rdata === 8'h67 && svc_rdata === 8'h9A, "reset values");
    chk(mode_locked === 1'b0 && guard_running === 1'b1, "not started");
    sc_lock();
    sc_ovf();
    sc_nmi();
    sc_stop();
    sc_main();
    stop_test();
  end
endmodule : tb_write_once_watchdog_timer
